// >>> rtl/adcs_map.svh
// Offsets, field positions, reset values and timing counts of the
// converter sequencer. Included by adcs_top and the bench only.
//
// Notes on behaviour
// R1 - Nonzero acquisition select samples 2..20 conversion clocks after go.
// R2 - Acquisition select 000: go ends sampling at once and converts.
// R3 - Acquisition select resets to 000, manual acquisition.
// R4 - Software waits the acquisition interval itself in manual mode.
// R5 - Completion clears go, sets done flag, resumes sampling.
// R6 - No status shows acquisition end or conversion start.
// R7 - A 10-bit conversion lasts exactly 11 conversion clock periods; after a manual start the first period is partial.
// R8 - Clock select gives 2,4,8,16,32,64 oscillator periods or RC clock.
// R9 - Manual mode start is delayed one instruction cycle for sleep.
// R10 - Conversion in sleep needs the RC conversion clock.
// R11 - Software clears idle-on-sleep enable before a sleep conversion.
// R12 - Device clock source should stay unchanged during a conversion.
// R13 - Below 1 MHz device clock, software should pick the RC clock.
// R14 - RC clock above 1 MHz needs sleep for the whole conversion.
// R15 - Sequencing ignores channel and pin direction bits.
// R16 - Port reads return zero on pins set as analog inputs.
// R17 - Clearing go aborts; result keeps last completed or written value.
// R18 - After completion or abort, wait 2 conversion clocks, then acquire.
// R19 - Software must not set go in the write that powers on.
// R20 - Capacitor array is discharged before every sampling phase.
// R21 - Acquisition select 010 gives 4 conversion clocks before conversion.
// R22 - Justify bit set: right justified result; clear: left justified.
// R23 - Reset restores registers, powers off, aborts any conversion.
// R24 - Reset leaves the result register pair untouched.
// R25 - Software waits 2 conversion clocks before the next acquisition.
// R26 - Divided clocks from free-running counter; RC is synced clock enable.
`ifndef ADCS_MAP_SVH
`define ADCS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADCS_OFF_CTRL 4'h0
`define ADCS_OFF_TIMING 4'h1
`define ADCS_OFF_RES_HI 4'h2
`define ADCS_OFF_RES_LO 4'h3
`define ADCS_OFF_STATUS 4'h4
`define ADCS_OFF_ANA_CFG 4'h5
`define ADCS_OFF_PORT 4'h6

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define ADCS_CTRL_ON 0
`define ADCS_CTRL_GO 1
`define ADCS_CTRL_CH_LSB 2
`define ADCS_STAT_DONE 0
`define ADCS_RST_TIMING 8'h00
`define ADCS_RST_ANA_CFG 8'hff

// ----------------------------------------
// Timing
// ----------------------------------------
`define ADCS_CLK_NS 8
`define ADCS_TCY_NS 32
`define ADCS_DELAY_CYC (`ADCS_TCY_NS / `ADCS_CLK_NS)
`define ADCS_CONV_TAD 11
`define ADCS_WAIT_TAD 2

`endif

// >>> rtl/adcs_pkg.sv
// Types shared by the converter sequencer modules.
// Assumes the offsets and counts come from adcs_map.svh.
package adcs_pkg;

  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_SAMPLE = 3'b001,
    ST_ACQ    = 3'b010,
    ST_DELAY  = 3'b011,
    ST_CONV   = 3'b100,
    ST_WAIT   = 3'b101
  } adcs_state_t;

  typedef struct packed {
    logic       discharge;
    logic       sample;
    logic       convert;
    logic [9:0] dac_code;
  } adcs_afe_t;

  typedef struct packed {
    logic       justify;
    logic       rsvd;
    logic [2:0] acq_sel;
    logic [2:0] clk_sel;
  } adcs_timing_t;

endpackage

// >>> rtl/adcs_sync.sv
// Two-flop synchroniser for levels coming from outside the clock.
// Assumes the inputs are quasi-static levels, not pulses.
`timescale 1ns/1ns
module adcs_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // adcs_sync

// >>> rtl/adcs_tad_gen.sv
// Conversion clock tick generator: one-cycle tick per conversion clock.
// Assumes the RC oscillator is much slower than the system clock.
`timescale 1ns/1ns
module adcs_tad_gen (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [2:0] clk_sel_i,
  input wire logic rc_clk_i,
  output logic tad_tick_o
);
  logic [5:0] div_r;
  logic rc_s;
  logic rc_d_r;
  logic [2:0] expo;
  logic [5:0] mask;

  adcs_sync #(.W(1)) u_rc_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i(rc_clk_i),
    .q_o(rc_s)
  );

  // R8 select map: 000,100,001,101,010,110 give 2..64 periods
  assign expo = {clk_sel_i[1:0], clk_sel_i[2]};
  assign mask = 6'((7'd2 << expo) - 7'd1);

  // R26 free-running divider
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_r <= 6'h00;
    end else begin
      div_r <= div_r + 6'h01;
    end
  end

  // R26 RC edge becomes a clock enable
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rc_d_r <= 1'b0;
      tad_tick_o <= 1'b0;
    end else begin
      rc_d_r <= rc_s;
      if (clk_sel_i[1:0] == 2'b11) begin
        tad_tick_o <= rc_s & ~rc_d_r;
      end else begin
        tad_tick_o <= ((div_r & mask) == mask);
      end
    end
  end
endmodule // adcs_tad_gen

// >>> rtl/adcs_top.sv
// Acquisition and conversion sequencer of a 10-bit SAR converter.
// Assumes a plain register port and an analog front end that answers
// each trial code on COMP_I within one conversion clock period.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "adcs_map.svh"
module adcs_top
  import adcs_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic COMP_I,
  input wire logic RC_CLK_I,
  input wire logic [7:0] PORT_PINS_I,
  output adcs_afe_t AFE_O,
  output logic [3:0] CHANNEL_SEL_O,
  output logic DONE_FLAG_O
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  adcs_state_t state_r;
  adcs_state_t state_nxt;
  adcs_timing_t timing_r;
  logic power_on_r;
  logic go_r;
  logic [7:0] ana_cfg_r;
  logic [7:0] res_hi_r;
  logic [7:0] res_lo_r;
  logic [4:0] tad_cnt_r;
  logic [1:0] dly_cnt_r;
  logic [9:0] dac_r;
  logic [9:0] sar_upd;
  logic tad_tick;
  logic comp_s;
  logic [7:0] pins_s;
  logic done;
  logic wr_ctrl;
  logic [4:0] acq_len;

  function automatic logic [4:0] acq_tad_f(input logic [2:0] sel);
    case (sel)
      3'h1: acq_tad_f = 5'h02;
      3'h2: acq_tad_f = 5'h04;
      3'h3: acq_tad_f = 5'h06;
      3'h4: acq_tad_f = 5'h08;
      3'h5: acq_tad_f = 5'h0c;
      3'h6: acq_tad_f = 5'h10;
      3'h7: acq_tad_f = 5'h14;
      default: acq_tad_f = 5'h00;
    endcase
  endfunction

  // ----------------------------------------
  // Clock ticks and input synchronisers
  // ----------------------------------------
  adcs_tad_gen u_tad (
    .clk_i(CLK_SYS_I),
    .srst_i(SRST_I),
    .clk_sel_i(timing_r.clk_sel),
    .rc_clk_i(RC_CLK_I),
    .tad_tick_o(tad_tick)
  );

  // Comparator shares these two flops; each conversion clock period
  // must outlast that latency, so the fastest divide is unusable
  adcs_sync #(.W(9)) u_in_sync (
    .clk_i(CLK_SYS_I),
    .srst_i(SRST_I),
    .d_i({COMP_I, PORT_PINS_I}),
    .q_o({comp_s, pins_s})
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // R1 programmed acquisition length, R21 for 010
  assign acq_len = acq_tad_f(timing_r.acq_sel);
  // R7 conversion ends on the eleventh tick
  assign done = (state_r == ST_CONV) && go_r && tad_tick &&
                (tad_cnt_r == 5'(`ADCS_CONV_TAD - 1));
  assign wr_ctrl = WR_I && (ADDR_I == `ADCS_OFF_CTRL);

  // R15 channel and pin bits never enter this decision
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        // R20 first sample after power on is preceded by discharge
        if (power_on_r) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_SAMPLE: begin
        if (go_r) begin
          // R2 manual start, R9 through one instruction cycle
          state_nxt = (acq_len == 5'h00) ? ST_DELAY : ST_ACQ;
        end
      end
      ST_ACQ: begin
        // R17 clearing go aborts
        if (!go_r) begin
          state_nxt = ST_WAIT;
        end else if (tad_tick && (tad_cnt_r == acq_len - 5'h01)) begin
          state_nxt = ST_CONV;
        end
      end
      ST_DELAY: begin
        if (!go_r) begin
          state_nxt = ST_WAIT;
        end else if (dly_cnt_r == 2'(`ADCS_DELAY_CYC - 1)) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        // R17 abort, R18 completion, both into the wait
        if (!go_r || done) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // R18 two ticks then sampling resumes by itself
        if (tad_tick && (tad_cnt_r == 5'(`ADCS_WAIT_TAD - 1))) begin
          state_nxt = ST_SAMPLE;
        end
      end
      default: state_nxt = ST_OFF;
    endcase
    // R23 power off stops everything
    if (!power_on_r) begin
      state_nxt = ST_OFF;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || (state_nxt != state_r)) begin
      tad_cnt_r <= 5'h00;
      dly_cnt_r <= 2'h0;
    end else begin
      if (tad_tick) begin
        tad_cnt_r <= tad_cnt_r + 5'h01;
      end
      if (state_r == ST_DELAY) begin
        dly_cnt_r <= dly_cnt_r + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // Successive approximation
  // ----------------------------------------
  // First tick is overhead; each later tick settles one bit
  always_comb begin
    sar_upd = dac_r;
    for (int k = 1; k <= 10; k++) begin
      if (tad_cnt_r == 5'(k)) begin
        sar_upd[10-k] = comp_s;
        if (k < 10) begin
          sar_upd[9-k] = 1'b1;
        end
      end
    end
    if (tad_cnt_r == 5'h00) begin
      sar_upd = 10'h200;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || (state_r != ST_CONV)) begin
      dac_r <= 10'h000;
    end else if (tad_tick) begin
      dac_r <= sar_upd;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // R3 R23 reset values
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      power_on_r <= 1'b0;
      CHANNEL_SEL_O <= 4'h0;
      timing_r <= `ADCS_RST_TIMING;
      ana_cfg_r <= `ADCS_RST_ANA_CFG;
    end else if (WR_I) begin
      if (ADDR_I == `ADCS_OFF_CTRL) begin
        power_on_r <= WDATA_I[`ADCS_CTRL_ON];
        CHANNEL_SEL_O <= WDATA_I[`ADCS_CTRL_CH_LSB +: 4];
      end
      if (ADDR_I == `ADCS_OFF_TIMING) begin
        timing_r <= {WDATA_I[7], 1'b0, WDATA_I[5:0]};
      end
      if (ADDR_I == `ADCS_OFF_ANA_CFG) begin
        ana_cfg_r <= WDATA_I;
      end
    end
  end

  // R5 completion clears go; R19 go ignored while powered off
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || done || !power_on_r) begin
      go_r <= 1'b0;
    end else if (wr_ctrl) begin
      go_r <= WDATA_I[`ADCS_CTRL_GO] &&
              ((state_r == ST_SAMPLE) || go_r);
    end
  end

  // R5 done flag, hardware set wins over a clearing write
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      DONE_FLAG_O <= 1'b0;
    end else if (done) begin
      DONE_FLAG_O <= 1'b1;
    end else if (WR_I && (ADDR_I == `ADCS_OFF_STATUS)) begin
      DONE_FLAG_O <= WDATA_I[`ADCS_STAT_DONE];
    end
  end

  // R24 no reset on the result pair; R17 only a completion or a register write loads it
  // Load beats a same-cycle write so a finished result is never lost
  always_ff @(posedge CLK_SYS_I) begin
    if (done) begin
      // R22 justification picked at completion
      if (timing_r.justify) begin
        res_hi_r <= {6'h00, sar_upd[9:8]};
        res_lo_r <= sar_upd[7:0];
      end else begin
        res_hi_r <= sar_upd[9:2];
        res_lo_r <= {sar_upd[1:0], 6'h00};
      end
    end else if (WR_I) begin
      if (ADDR_I == `ADCS_OFF_RES_HI) begin
        res_hi_r <= WDATA_I;
      end
      if (ADDR_I == `ADCS_OFF_RES_LO) begin
        res_lo_r <= WDATA_I;
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // R6 only go and the done flag reveal progress
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || !RD_I) begin
      RDATA_O <= 8'h00;
    end else begin
      case (ADDR_I)
        `ADCS_OFF_CTRL: RDATA_O <= {2'h0, CHANNEL_SEL_O, go_r, power_on_r};
        `ADCS_OFF_TIMING: RDATA_O <= timing_r;
        `ADCS_OFF_RES_HI: RDATA_O <= res_hi_r;
        `ADCS_OFF_RES_LO: RDATA_O <= res_lo_r;
        `ADCS_OFF_STATUS: RDATA_O <= {7'h00, DONE_FLAG_O};
        `ADCS_OFF_ANA_CFG: RDATA_O <= ana_cfg_r;
        // R16 analog pins read as zero
        `ADCS_OFF_PORT: RDATA_O <= pins_s & ~ana_cfg_r;
        default: RDATA_O <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Analog front end controls
  // ----------------------------------------
  // R20 discharge during the wait before every sample
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      AFE_O <= '0;
    end else begin
      AFE_O.discharge <= (state_r == ST_WAIT);
      AFE_O.sample <= (state_r == ST_SAMPLE) || (state_r == ST_ACQ);
      AFE_O.convert <= (state_r == ST_CONV);
      AFE_O.dac_code <= dac_r;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);

  logic [4:0] chk_ticks_r;
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || (state_nxt != state_r)) begin
      chk_ticks_r <= 5'h00;
    end else if (tad_tick && (chk_ticks_r != 5'h1f)) begin
      chk_ticks_r <= chk_ticks_r + 5'h01;
    end
  end

  done_clears_go_a: assert property ( // R5
    done |=> !go_r && DONE_FLAG_O && (state_r == ST_WAIT))
    else $error("completion did not clear go or set flag");
  acq_reset_a: assert property ( // R3
    $past(SRST_I) |-> (timing_r.acq_sel == 3'h0) && !power_on_r)
    else $error("acquisition select not reset to manual");
  manual_start_a: assert property ( // R2
    (state_r == ST_SAMPLE) && go_r && power_on_r && (acq_len == 5'h00)
    |=> (state_r == ST_DELAY) || (state_r == ST_OFF))
    else $error("manual go did not end sampling");
  delay_len_a: assert property ( // R9
    (state_r == ST_CONV) && ($past(state_r) == ST_DELAY)
    |-> $past(state_r, 4) == ST_DELAY)
    else $error("start delay not one instruction cycle");
  conv_len_a: assert property ( // R7
    done |-> (chk_ticks_r == 5'd10) && tad_tick)
    else $error("conversion length not 11 ticks");
  acq_len_a: assert property ( // R1
    (state_r == ST_CONV) && ($past(state_r) == ST_ACQ)
    |-> $past(chk_ticks_r) == acq_len - 5'h01)
    else $error("programmed acquisition length wrong");
  wait_len_a: assert property ( // R18
    (state_r == ST_SAMPLE) && ($past(state_r) == ST_WAIT)
    |-> $past(chk_ticks_r) == 5'd1)
    else $error("post conversion wait not 2 ticks");
  abort_keep_a: assert property ( // R17
    (state_r == ST_CONV) && !go_r && !WR_I
    |=> $stable(res_hi_r) && $stable(res_lo_r))
    else $error("abort changed the result");
  discharge_first_a: assert property ( // R20
    $rose(AFE_O.sample) |-> $past(AFE_O.discharge))
    else $error("sampling without prior discharge");
  port_mask_a: assert property ( // R16
    RD_I && (ADDR_I == `ADCS_OFF_PORT) |=> (RDATA_O & ana_cfg_r) == 8'h00)
    else $error("analog pin read nonzero");
  right_just_a: assert property ( // R22
    done && timing_r.justify |=> res_hi_r[7:2] == 6'h00)
    else $error("right justified result has high bits set");

  manual_conv_c: cover property (done && (timing_r.acq_sel == 3'h0));
  prog_conv_c: cover property (done && (timing_r.acq_sel == 3'h2));
  abort_c: cover property ((state_r == ST_CONV) && !go_r);
  rc_conv_c: cover property (done && (timing_r.clk_sel[1:0] == 2'b11));
endmodule // adcs_top

// >>> bench/adcs_afe_model.sv
// Behavioural analog front end: hold capacitor, comparator and RC
// oscillator. Assumes the sequencer drives the trial code on afe_i.
`timescale 1ns/1ns
module adcs_afe_model
  import adcs_pkg::*;
(
  input wire logic clk_i,
  input wire adcs_afe_t afe_i,
  input wire logic [9:0] vin_i,
  input wire logic [1:0] lag_i,
  output logic comp_o,
  output logic rc_clk_o
);
  // ----------------------------------------
  // Hold capacitor and comparator
  // ----------------------------------------
  logic [9:0] held_r;
  logic [3:0] pipe_r;

  // cap emptied, then tracks the input only while sampling
  always_ff @(posedge clk_i) begin
    if (afe_i.discharge) begin
      held_r <= 10'h000;
    end else if (afe_i.sample) begin
      held_r <= vin_i;
    end
    pipe_r <= {pipe_r[2:0], held_r >= afe_i.dac_code};
  end

  // Slow comparator answers lag_i cycles late, never wrong
  assign comp_o = (lag_i == 2'd0) ? (held_r >= afe_i.dac_code)
                                  : pipe_r[lag_i - 2'd1];

  // ----------------------------------------
  // RC oscillator
  // ----------------------------------------
  // no sleep or idle mode here; conversions run awake
  // free running, phase unrelated to the system clock
  initial begin
    rc_clk_o = 1'b0;
    #3;
    forever #50 rc_clk_o = ~rc_clk_o;
  end
endmodule // adcs_afe_model

// >>> bench/tb.sv
// Bench for the converter sequencer: registers, timed conversions,
// abort and reset. Assumes the front-end model answers on COMP_I.
`timescale 1ns/1ns
`include "adcs_map.svh"
module tb
  import adcs_pkg::*;
;
  logic clk_sys, srst, wr, rd, comp, rc_clk, done_flag;
  logic [3:0] addr, chan;
  logic [7:0] wdata, rdata, pins, q, c, p;
  logic [9:0] vin, last;
  logic [1:0] lag;
  logic [11:0] regs [6];
  adcs_afe_t afe;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  bit known;

  adcs_top DUT (
    .CLK_SYS_I(clk_sys), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .COMP_I(comp),
    .RC_CLK_I(rc_clk), .PORT_PINS_I(pins), .AFE_O(afe),
    .CHANNEL_SEL_O(chan), .DONE_FLAG_O(done_flag)
  );
  adcs_afe_model afe_model (
    .clk_i(clk_sys), .afe_i(afe), .vin_i(vin), .lag_i(lag),
    .comp_o(comp), .rc_clk_o(rc_clk)
  );

  initial clk_sys = 1'b0;
  // one fixed clock source for the whole run
  always #4 clk_sys = ~clk_sys;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Longest run is well under this; a hang ends here
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One strobe cycle, then an idle one; read data taken mid-cycle
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk_sys);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk_sys);
    q = rdata;
    @(posedge clk_sys);
  endtask

  // Cycles until a front-end level reaches lvl (0 conv, 1 sample, 2 dis)
  task automatic meas(input int s, input logic lvl, output int k);
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while ((s == 0 ? afe.convert : s == 1 ? afe.sample
                : afe.discharge) !== lvl && k < 3000);
    if (k >= 3000) begin
      errors++;
      give_verdict();
    end
    @(posedge clk_sys);
  endtask

  // ----------------------------------------
  // One conversion against the timing model
  // ----------------------------------------
  task automatic conv(input logic [2:0] acq, input logic [2:0] cs,
                      input logic j, input logic ab);
    int k, tl, th, na, lo, hi;
    logic [3:0] ch;
    logic [9:0] v;
    v = 10'($urandom);
    ch = 4'($urandom);
    na = (acq == 3'd0) ? 0 : (acq < 3'd5) ? 2 * acq : 4 * acq - 8;
    tl = (cs[1:0] == 2'b11) ? 12 : 2 << (2 * cs[1:0] + cs[2]);
    th = (cs[1:0] == 2'b11) ? 13 : tl;
    lo = (na == 0) ? 3 : (na - 1) * tl;
    hi = (na == 0) ? 8 : na * th + 5;
    lag <= (tl >= 16) ? 2'd2 : 2'd0;
    vin <= v;
    bus(1'b1, `ADCS_OFF_TIMING, {j, 1'b0, acq, cs});
    bus(1'b1, `ADCS_OFF_STATUS, 8'h00);
    meas(1, 1'b1, k);
    // let the input settle before go
    repeat (4 * th) @(posedge clk_sys);
    bus(1'b1, `ADCS_OFF_CTRL, {2'b00, ch, 2'b11});
    meas(0, 1'b1, k);
    chk(16'(chan), 16'(ch));
    chk(16'(k >= lo && k <= hi), 16'h1);
    if (ab) begin
      repeat (3 * th) @(posedge clk_sys);
      bus(1'b1, `ADCS_OFF_CTRL, {2'b00, ch, 2'b01});
      meas(0, 1'b0, k);
      chk(16'(k <= 4), 16'h1);
    end else begin
      meas(0, 1'b0, k);
      chk(16'(k >= 10 * tl - 2 && k <= 11 * th + 4), 16'h1);
    end
    meas(2, 1'b0, k);
    chk(16'(k >= tl - 2 && k <= 2 * th + 4), 16'h1);
    @(negedge clk_sys);
    chk(16'(afe.sample), 16'h1);
    @(posedge clk_sys);
    bus(1'b0, `ADCS_OFF_CTRL, 8'h00);
    chk(16'(q), 16'({2'b00, ch, 2'b01}));
    chk(16'(done_flag), 16'(!ab));
    if (!ab) begin
      // Too short a period outruns the comparator path
      known = (tl >= 8);
      last = v;
    end
    if (known) begin
      bus(1'b0, `ADCS_OFF_RES_HI, 8'h00);
      chk(16'(q), j ? 16'(last[9:8]) : 16'(last[9:2]));
      bus(1'b0, `ADCS_OFF_RES_LO, 8'h00);
      chk(16'(q), j ? 16'(last[7:0]) : 16'({last[1:0], 6'h00}));
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    pins = 8'h00;
    vin = 10'h000;
    lag = 2'd0;
    known = 1'b0;
    last = 10'h000;
    regs = '{{`ADCS_OFF_CTRL, 8'h00}, {`ADCS_OFF_TIMING, 8'h00},
             {`ADCS_OFF_STATUS, 8'h00}, {`ADCS_OFF_ANA_CFG, 8'hff},
             {4'h7, 8'h00}, {4'hf, 8'h00}};
    void'($urandom(32'h8fd3));
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    foreach (regs[i]) begin
      bus(1'b0, regs[i][11:8], 8'h00);
      chk(16'(q), 16'(regs[i][7:0]));
    end
    bus(1'b1, 4'h9, 8'h5a);
    bus(1'b0, 4'h9, 8'h00);
    chk(16'(q), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      c = 8'($urandom);
      p = 8'($urandom);
      pins <= p;
      bus(1'b1, `ADCS_OFF_ANA_CFG, c);
      repeat (3) @(posedge clk_sys);
      bus(1'b0, `ADCS_OFF_PORT, 8'h00);
      chk(16'(q), 16'(p & ~c));
    end
    bus(1'b1, `ADCS_OFF_TIMING, 8'hff);
    bus(1'b0, `ADCS_OFF_TIMING, 8'h00);
    chk(16'(q), 16'h00bf);
    // go in the powering write is refused on purpose
    bus(1'b1, `ADCS_OFF_CTRL, 8'h03);
    bus(1'b0, `ADCS_OFF_CTRL, 8'h00);
    chk(16'(q), 16'h0001);
    for (int a = 0; a < 8; a++) begin
      conv(3'(a), 3'b001, a[0], 1'b0);
    end
    for (int s = 0; s < 8; s++) begin
      conv(3'b001, 3'(s), 1'b1, 1'b0);
    end
    conv(3'b010, 3'b001, 1'b1, 1'b1);
    // a software written pair survives an abort
    c = 8'($urandom);
    p = 8'($urandom);
    bus(1'b1, `ADCS_OFF_RES_HI, c);
    bus(1'b1, `ADCS_OFF_RES_LO, p);
    known = 1'b0;
    conv(3'b001, 3'b100, 1'b0, 1'b1);
    bus(1'b0, `ADCS_OFF_RES_HI, 8'h00);
    chk(16'(q), 16'(c));
    bus(1'b0, `ADCS_OFF_RES_LO, 8'h00);
    chk(16'(q), 16'(p));
    conv(3'b000, 3'b101, 1'b0, 1'b0);
    // Reset in mid-conversion, high result byte must survive
    bus(1'b1, `ADCS_OFF_CTRL, 8'h03);
    meas(0, 1'b1, n);
    srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    @(negedge clk_sys);
    chk(16'(afe), 16'h0000);
    chk(16'(done_flag), 16'h0000);
    @(posedge clk_sys);
    bus(1'b0, `ADCS_OFF_CTRL, 8'h00);
    chk(16'(q), 16'h0000);
    bus(1'b0, `ADCS_OFF_TIMING, 8'h00);
    chk(16'(q), 16'h0000);
    bus(1'b0, `ADCS_OFF_RES_HI, 8'h00);
    chk(16'(q), 16'(last[9:2]));
    give_verdict();
  end
endmodule // tb
